// *** logic/gauge_status_capacity_regs.sv ***
// Status flags and capacity register bank of the battery gauge
// Functional notes
// RQ1: Stale flag sets at 64th charge without update or reset; clears on update.
// RQ2: Valid discharge flag sets on first discharge from full; held until update.
// RQ3: Self-discharge over 6% since setting clears the valid discharge flag.
// RQ4: Valid charge held for two capacity updates clears the valid discharge flag.
// RQ5: First empty warning below 0 C clears valid discharge flag; reset too.
// RQ6: First empty warning sets below threshold at rate under 2C; held until charge.
// RQ7: First LED segment blinks at 4 Hz while display on and first warning set.
// RQ8: Final warning at threshold minus 25 mV blanks segments; held until charge.
// RQ9: Temperature band code in upper nibble at 02h, 10 C bands.
// RQ10: Lower nibble holds compensated level over full reference in sixteenths.
// RQ11: Capacity counter at 03h/17h counts charge up, discharge down; reset zero.
// RQ12: Host must not write capacity above full reference.
// RQ13: Battery tag at 04h is host storage only, no defined reset value. Code clears it to 00h on power-on reset and keeps it on command reset.
// RQ14: Full reference at 05h loads programmed full count on reset.
// RQ15: First charge after empty warning with valid discharge loads discharge count.
// RQ16: Discharge count under 94 percent gives 94 percent of old reference.
// RQ17: Host must not write reserved bits 7 and 1 of secondary status.
// RQ18: Secondary bits 6-4 report discharge rate regime codes.
// RQ19: Host ignores the sense activity test bit.
// RQ20: Valid charge flag sets on charge, clears on first discharge from full.
// RQ21: Overload follows rate over 2C, clears 0.5 s later, stops voltage sampling.
// RQ22: Pull-down register bit n-1 reports a pull-down on segment n.
// RQ23: Temperature codes never exceed 1100.
`timescale 1ns/1ps
module gauge_status_capacity_regs
  import gauge_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC,
  parameter int unsigned OVERLOAD_FLAG_HOLD_CYCLES  = OVERLOAD_FLAG_HOLD_CYC
)
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              soft_reset,
  input  wire logic        [6:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic        [7:0] reg_wdata,
  output logic             [7:0] reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic              charge_tick,
  input  wire logic              discharge_tick,
  input  wire logic              self_discharge_tick,
  input  wire logic              valid_charge,
  input  wire logic        [7:0] cell_voltage,
  input  wire logic        [7:0] volt_threshold,
  input  wire logic              rate_half_c,
  input  wire logic              rate_over_2c,
  input  wire logic signed [7:0] temperature_c,
  input  wire logic        [7:0] compensated_level,
  input  wire logic        [7:0] discharge_count,
  input  wire logic        [7:0] programmed_full_count,
  input  wire logic              display_enable,
  input  wire logic        [4:0] segment_pattern,
  input  wire logic        [4:0] pulldown_seen,
  input  wire logic              protector_status,
  input  wire logic              sense_activity,
  output logic             [4:0] seg_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] nominal_capacity;
    logic [7:0]  full_ref;
    logic [7:0]  tag;
    logic        stale;
    logic [7:0]  chg_cnt;
    logic        valid_discharge_flag;
    logic [15:0] vdq_nac;
    logic [15:0] sd_acc;
    logic [1:0]  vq_upd;
    logic        first_empty_warning;
    logic        final_empty_warning;
    logic        vq;
    logic        brp;
    logic        overload_flag;
    logic [31:0] overload_flag_cnt;
    logic [31:0] blink_cnt;
    logic        blink;
    logic        vc_prev;
    logic [7:0]  temp_gauge;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [4:0]  seg;
  } state_t;

  state_t q;
  state_t d;

  logic [3:0]  temp_code;
  logic [3:0]  gauge_level;
  logic        vc_rise;
  logic        at_full;
  logic        dis_from_full;
  logic        first_empty_warning_set;
  logic        final_empty_warning_set;
  logic [7:0]  final_empty_warning_thr;
  logic        lmd_upd;
  logic [15:0] lmd_scaled;
  logic [7:0]  lmd_next;
  logic [2:0]  rate_code;
  logic        wr_capacity_count_high;
  logic        wr_capacity_count_low;
  logic        wr_lmd;
  logic        any_reset;

  temp_gauge_encode u_encode (
    .temperature_c     (temperature_c),
    .compensated_level (compensated_level),
    .full_reference    (q.full_ref),
    .temp_code         (temp_code),
    .sixteenths_level  (gauge_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d             = q;
    any_reset     = ~reset_n | soft_reset;
    vc_rise       = valid_charge & ~q.vc_prev;
    at_full       = (q.nominal_capacity[15:8] == q.full_ref);
    dis_from_full = discharge_tick & at_full;
    wr_capacity_count_high       = reg_wr & (reg_addr == ADDR_CAP_HIGH);
    wr_capacity_count_low       = reg_wr & (reg_addr == ADDR_CAP_LOW);
    wr_lmd        = reg_wr & (reg_addr == ADDR_FULL_REF);
    final_empty_warning_thr      = (volt_threshold > FINAL_OFFSET_CNT) ? 8'(volt_threshold - FINAL_OFFSET_CNT) : 8'h00;
    first_empty_warning_set      = ~q.overload_flag & ~rate_over_2c & (cell_voltage < volt_threshold);   // see RQ6 see RQ21
    final_empty_warning_set      = ~q.overload_flag & ~rate_over_2c & (cell_voltage < final_empty_warning_thr);         // see RQ8
    lmd_upd       = vc_rise & q.first_empty_warning & q.valid_discharge_flag;                                     // see RQ15
    lmd_scaled    = 16'((32'(q.full_ref) * REF_SCALE_PCT) / PCT_FULL);
    if ((32'(discharge_count) * PCT_FULL) < (32'(q.full_ref) * REF_SCALE_PCT))
      lmd_next    = lmd_scaled[7:0];                                              // see RQ16
    else
      lmd_next    = discharge_count;                                              // see RQ15
    rate_code     = rate_over_2c ? RATE_HIGH : (rate_half_c ? RATE_MID : RATE_LOW);
    d.vc_prev     = valid_charge;

    // Capacity counter
    if (charge_tick && (q.nominal_capacity[15:8] < q.full_ref))
      d.nominal_capacity = 16'(q.nominal_capacity + 16'h0001);                                             // see RQ11
    else if ((discharge_tick || self_discharge_tick) && (q.nominal_capacity != CAP_RESET))
      d.nominal_capacity = 16'(q.nominal_capacity - 16'h0001);                                             // see RQ11

    // Overload with hold-off after the rate drops
    if (rate_over_2c)
    begin
      d.overload_flag     = 1'b1;                                                          // see RQ21
      d.overload_flag_cnt = OVERLOAD_FLAG_HOLD_CYCLES;
    end
    else if (q.overload_flag)
    begin
      if (q.overload_flag_cnt <= 32'h0000_0001)
      begin
        d.overload_flag     = 1'b0;                                                        // see RQ21
        d.overload_flag_cnt = 32'h0000_0000;
      end
      else
        d.overload_flag_cnt = q.overload_flag_cnt - 32'h0000_0001;
    end

    // Empty warnings, set wins over the charge clear
    if (vc_rise)
    begin
      d.first_empty_warning = 1'b0;
      d.final_empty_warning = 1'b0;
    end
    if (first_empty_warning_set)
      d.first_empty_warning = 1'b1;                                                              // see RQ6
    if (final_empty_warning_set)
      d.final_empty_warning = 1'b1;                                                              // see RQ8

    // Charges since last reference update
    if (vc_rise && (q.chg_cnt != CHARGES_MAX))
      d.chg_cnt = 8'(q.chg_cnt + 8'h01);
    if (d.chg_cnt >= STALE_CHARGES)
      d.stale = 1'b1;                                                             // see RQ1

    // Valid discharge qualification
    if (!q.valid_discharge_flag)
    begin
      if (dis_from_full)
      begin
        d.valid_discharge_flag     = 1'b1;                                                         // see RQ2
        d.vdq_nac = q.nominal_capacity;
        d.sd_acc  = 16'h0000;
        d.vq_upd  = 2'h0;
      end
    end
    else
    begin
      if (self_discharge_tick && (q.sd_acc != 16'hFFFF))
        d.sd_acc = 16'(q.sd_acc + 16'h0001);
      if (!valid_charge)
        d.vq_upd = 2'h0;
      else if (charge_tick && (q.vq_upd != CHARGE_UPDATES))
        d.vq_upd = 2'(q.vq_upd + 2'h1);
      if ((32'(d.sd_acc) * PCT_FULL) > (32'(q.vdq_nac) * SELF_DIS_PCT))
        d.valid_discharge_flag = 1'b0;                                                             // see RQ3
      if (d.vq_upd == CHARGE_UPDATES)
        d.valid_discharge_flag = 1'b0;                                                             // see RQ4
      if (first_empty_warning_set && !q.first_empty_warning && (temperature_c < 8'sd0))
        d.valid_discharge_flag = 1'b0;                                                             // see RQ5
    end

    // Valid charge and battery replaced flags
    if (dis_from_full)
      d.vq = 1'b0;                                                                // see RQ20
    if (vc_rise)
      d.vq = 1'b1;                                                                // see RQ20
    if ((vc_rise && q.first_empty_warning) || (charge_tick && at_full))
      d.brp = 1'b0;

    // Full reference update
    if (lmd_upd)
    begin
      d.full_ref = lmd_next;                                                      // see RQ15 see RQ16
      d.stale    = 1'b0;                                                          // see RQ1
      d.chg_cnt  = 8'h00;
      d.valid_discharge_flag      = 1'b0;                                                          // see RQ2
    end

    // Host writes
    if (wr_capacity_count_high)
      d.nominal_capacity[15:8] = reg_wdata;                                                    // see RQ12
    if (wr_capacity_count_low)
      d.nominal_capacity[7:0] = reg_wdata;
    if (reg_wr && (reg_addr == ADDR_BATT_TAG))
      d.tag = reg_wdata;                                                          // see RQ13
    if (wr_lmd)
      d.full_ref = reg_wdata;

    // Gauge register and blink timebase
    d.temp_gauge = {temp_code, gauge_level};                                      // see RQ9 see RQ10
    if (q.blink_cnt >= (BLINK_HALF_CYCLES - 32'h0000_0001))
    begin
      d.blink_cnt = 32'h0000_0000;
      d.blink     = ~q.blink;
    end
    else
      d.blink_cnt = q.blink_cnt + 32'h0000_0001;

    // Segment drive
    if (!display_enable || q.final_empty_warning)
      d.seg = 5'h00;                                                              // see RQ8
    else
      d.seg = {segment_pattern[4:1], segment_pattern[0] & (~q.first_empty_warning | q.blink)};   // see RQ7

    // Register reads
    d.rvalid = reg_rd;
    d.rdata  = RDATA_IDLE;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_STATUS_PRI:
        begin
          d.rdata[PRI_CHARGING] = valid_charge;
          d.rdata[PRI_REPLACED] = q.brp;
          d.rdata[PRI_PROTECT]  = protector_status;
          d.rdata[PRI_STALE]    = q.stale;
          d.rdata[PRI_VALID_DIS]  = q.valid_discharge_flag;
          d.rdata[PRI_ONE]        = 1'b1;
          d.rdata[PRI_WARN_FIRST] = q.first_empty_warning;
          d.rdata[PRI_WARN_FINAL] = q.final_empty_warning;
        end
        ADDR_TEMP_GAUGE: d.rdata = q.temp_gauge;
        ADDR_CAP_HIGH:   d.rdata = q.nominal_capacity[15:8];
        ADDR_CAP_LOW:    d.rdata = q.nominal_capacity[7:0];
        ADDR_BATT_TAG:   d.rdata = q.tag;
        ADDR_FULL_REF:   d.rdata = q.full_ref;
        ADDR_STATUS_SEC:
        begin
          d.rdata[SEC_RATE_LSB +: 3] = rate_code;                                 // see RQ18
          d.rdata[SEC_SENSE]         = sense_activity;                            // see RQ19
          d.rdata[SEC_VALID_CHG]     = q.vq;
          d.rdata[SEC_OVERLOAD]      = q.overload_flag;                                    // see RQ17
        end
        ADDR_PULLDOWN:   d.rdata = {3'h0, pulldown_seen};                         // see RQ22
        default:         d.rdata = RDATA_IDLE;
      endcase
    end

    // Power-on or command reset
    if (any_reset)
    begin
      d          = '0;
      d.nominal_capacity      = CAP_RESET;                                                     // see RQ11
      d.full_ref = programmed_full_count;                                         // see RQ14
      d.stale    = 1'b1;                                                          // see RQ1
      d.brp      = 1'b1;
      d.valid_discharge_flag      = 1'b0;                                                          // see RQ5
      d.tag      = reset_n ? q.tag : TAG_RESET;                                   // see RQ13
    end
  end

  always_ff @(posedge mclk)
  begin
    q <= d;
  end

  assign reg_rdata  = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign seg_drive  = q.seg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_tag_write;
    reg_wr && (reg_addr == ADDR_BATT_TAG) && !soft_reset;
  endsequence

  sequence s_sec_read;
    reg_rd && (reg_addr == ADDR_STATUS_SEC) && !soft_reset;
  endsequence

  property p_reset_state;
    @(posedge mclk) disable iff (!reset_n)
    soft_reset |=> (q.nominal_capacity == CAP_RESET) && q.stale && !q.valid_discharge_flag && (q.full_ref == $past(programmed_full_count));
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // see RQ11 see RQ14

  property p_vdq_set;
    @(posedge mclk) disable iff (!reset_n)
    (dis_from_full && !q.valid_discharge_flag && !vc_rise && !soft_reset) |=> q.valid_discharge_flag && !q.vq;
  endproperty
  a_vdq_set: assert property (p_vdq_set) else $error("valid discharge not set"); // see RQ2

  property p_lmd_update;
    @(posedge mclk) disable iff (!reset_n)
    (lmd_upd && !wr_lmd && !soft_reset) |=> (q.full_ref == $past(lmd_next)) && !q.stale && !q.valid_discharge_flag;
  endproperty
  a_lmd_update: assert property (p_lmd_update) else $error("full reference update wrong"); // see RQ15

  property p_lmd_scale;
    @(posedge mclk) disable iff (!reset_n)
    ((32'(discharge_count) * PCT_FULL) < (32'(q.full_ref) * REF_SCALE_PCT)) |-> (lmd_next == lmd_scaled[7:0]);
  endproperty
  a_lmd_scale: assert property (p_lmd_scale) else $error("scaled reference wrong"); // see RQ16

  property p_vdq_charge;
    @(posedge mclk) disable iff (!reset_n)
    (q.valid_discharge_flag && (q.vq_upd == 2'h1) && charge_tick && valid_charge) |=> !q.valid_discharge_flag;
  endproperty
  a_vdq_charge: assert property (p_vdq_charge) else $error("sustained charge kept valid discharge"); // see RQ4

  property p_first_empty_warning_set;
    @(posedge mclk) disable iff (!reset_n)
    (first_empty_warning_set && !soft_reset) |=> q.first_empty_warning ##1 (q.first_empty_warning || $past(vc_rise) || $past(soft_reset));
  endproperty
  a_first_empty_warning_set: assert property (p_first_empty_warning_set) else $error("first empty warning not latched"); // see RQ6

  property p_final_empty_warning_blank;
    @(posedge mclk) disable iff (!reset_n)
    (q.final_empty_warning && !soft_reset) |=> (seg_drive == 5'h00);
  endproperty
  a_final_empty_warning_blank: assert property (p_final_empty_warning_blank) else $error("segments lit at final empty"); // see RQ8

  property p_overload_flag;
    @(posedge mclk) disable iff (!reset_n)
    (rate_over_2c && !soft_reset) |=> q.overload_flag ##0 !first_empty_warning_set;
  endproperty
  a_overload_flag: assert property (p_overload_flag) else $error("overload not held"); // see RQ21

  property p_temp_code;
    @(posedge mclk) disable iff (!reset_n)
    q.temp_gauge[7:4] <= TEMP_CODE_MAX;
  endproperty
  a_temp_code: assert property (p_temp_code) else $error("temperature code out of range"); // see RQ23

  property p_rate_read;
    @(posedge mclk) disable iff (!reset_n)
    s_sec_read |=> reg_rvalid && (reg_rdata[SEC_RATE_LSB +: 3] == $past(rate_code));
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("rate field read wrong"); // see RQ18

  property p_tag_write;
    @(posedge mclk) disable iff (!reset_n)
    s_tag_write |=> (q.tag == $past(reg_wdata));
  endproperty
  a_tag_write: assert property (p_tag_write) else $error("battery tag not stored"); // see RQ13

endmodule // gauge_status_capacity_regs

// *** logic/gauge_pkg.sv ***
// Constants shared by the gauge status and capacity register bank
package gauge_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [6:0] ADDR_STATUS_PRI = 7'h01;
  localparam logic [6:0] ADDR_TEMP_GAUGE = 7'h02;
  localparam logic [6:0] ADDR_CAP_HIGH   = 7'h03;
  localparam logic [6:0] ADDR_BATT_TAG   = 7'h04;
  localparam logic [6:0] ADDR_FULL_REF   = 7'h05;
  localparam logic [6:0] ADDR_STATUS_SEC = 7'h06;
  localparam logic [6:0] ADDR_PULLDOWN   = 7'h07;
  localparam logic [6:0] ADDR_CAP_LOW    = 7'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Primary status bit positions
  localparam int PRI_CHARGING  = 7;
  localparam int PRI_REPLACED  = 6;
  localparam int PRI_PROTECT   = 5;
  localparam int PRI_STALE     = 4;
  localparam int PRI_VALID_DIS  = 3;
  localparam int PRI_ONE        = 2;
  localparam int PRI_WARN_FIRST = 1;
  localparam int PRI_WARN_FINAL = 0;
  // Secondary status bit positions
  localparam int SEC_RATE_LSB  = 4;
  localparam int SEC_SENSE     = 3;
  localparam int SEC_VALID_CHG = 2;
  localparam int SEC_OVERLOAD  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits
  localparam logic [15:0] CAP_RESET       = 16'h0000;
  localparam logic [7:0]  TAG_RESET       = 8'h00;
  localparam logic [7:0]  RDATA_IDLE      = 8'h00;
  localparam logic [7:0]  STALE_CHARGES   = 8'h40;
  localparam logic [7:0]  CHARGES_MAX     = 8'hFF;
  localparam logic [1:0]  CHARGE_UPDATES  = 2'h2;
  localparam int          SELF_DIS_PCT    = 6;
  localparam int          REF_SCALE_PCT   = 94;
  localparam int          PCT_FULL        = 100;
  localparam logic [2:0]  RATE_LOW        = 3'h0;
  localparam logic [2:0]  RATE_MID        = 3'h1;
  localparam logic [2:0]  RATE_HIGH       = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Voltage and temperature scaling
  localparam int          FINAL_OFFSET_MV  = 25;
  localparam int          THRESH_LSB_UV    = 4688;
  localparam logic [7:0]  FINAL_OFFSET_CNT = 8'((FINAL_OFFSET_MV * 1000) / THRESH_LSB_UV);
  localparam int          TEMP_FLOOR_C    = -30;
  localparam int          TEMP_BAND_C     = 10;
  localparam logic [3:0]  TEMP_CODE_MAX   = 4'hC;
  localparam logic [3:0]  GAUGE_MAX       = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned BLINK_HZ        = 4;
  localparam int unsigned BLINK_HALF_CYC  = CLK_FREQ_HZ / (2 * BLINK_HZ);
  localparam int unsigned OVERLOAD_FLAG_HOLD_MS    = 500;
  localparam int unsigned OVERLOAD_FLAG_HOLD_CYC   = (CLK_FREQ_HZ / 1000) * OVERLOAD_FLAG_HOLD_MS;

endpackage

// *** logic/temp_gauge_encode.sv ***
// Temperature band code and sixteenths gauge encoder
`timescale 1ns/1ps
module temp_gauge_encode
  import gauge_pkg::*;
(
  input  wire logic signed [7:0] temperature_c,
  input  wire logic        [7:0] compensated_level,
  input  wire logic        [7:0] full_reference,
  output logic             [3:0] temp_code,
  output logic             [3:0] sixteenths_level
);

  logic [9:0]  t_ofs;
  logic [9:0]  band;
  logic [11:0] ratio;

  always_comb
  begin
    t_ofs = 10'(10'(signed'(temperature_c)) - 10'(TEMP_FLOOR_C) + 10'(TEMP_BAND_C));
    band  = t_ofs / 10'(TEMP_BAND_C);
    if (int'(temperature_c) < TEMP_FLOOR_C)
      temp_code = 4'h0;
    else if (band > 10'(TEMP_CODE_MAX))
      temp_code = TEMP_CODE_MAX;                             // see RQ23
    else
      temp_code = band[3:0];                                 // see RQ9
    ratio = 12'h000;
    if (full_reference != 8'h00)
      ratio = {compensated_level, 4'h0} / 12'(full_reference);
    if (ratio > 12'(GAUGE_MAX))
      sixteenths_level = GAUGE_MAX;                          // see RQ10
    else
      sixteenths_level = ratio[3:0];
  end

endmodule // temp_gauge_encode

// *** testbench/host_bus_model.sv ***
// Host side model of the gauge register bus
`timescale 1ns/1ps
module host_bus_model
  import gauge_pkg::*;
(
  input  wire logic       mclk,
  output logic      [6:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial
  begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write one byte; callers keep capacity at or below full_reference
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= (a == ADDR_STATUS_SEC) ? (d & 8'h7D) : d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // Read one byte; unknown if no answer, sense test bit dropped
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    if (a == ADDR_STATUS_SEC)
      d[SEC_SENSE] = 1'b0;
  endtask
endmodule // host_bus_model

// *** testbench/gauge_status_capacity_regs_test.sv ***
// Self-checking bench of the gauge status and capacity registers
`timescale 1ns/1ps
module gauge_status_capacity_regs_test
  import gauge_pkg::*;
;
  typedef struct {logic signed [7:0] t; logic [3:0] c;} temp_row_t;
  logic               mclk = 1'b0;
  logic               reset_n = 1'b0;
  logic               soft_reset = 1'b0;
  logic         [6:0] reg_addr;
  logic               reg_wr, reg_rd, reg_rvalid;
  logic         [7:0] reg_wdata, reg_rdata;
  logic               charge_tick = 1'b0, discharge_tick = 1'b0, self_discharge_tick = 1'b0;
  logic               valid_charge = 1'b0, rate_half_c = 1'b0, rate_over_2c = 1'b0;
  logic         [7:0] cell_voltage = 8'hC0, volt_threshold = 8'hA2;
  logic signed  [7:0] temperature_c = 8'sd25;
  logic         [7:0] compensated_level = 8'h08, discharge_count = 8'h0E, programmed_full_count = 8'h10;
  logic               display_enable = 1'b1, protector_status = 1'b0, sense_activity = 1'b0;
  logic         [4:0] segment_pattern = 5'h1F, pulldown_seen = 5'h09, seg_drive;
  int                 fails = 0, compares = 0, ones;
  temp_row_t          rows [9] = '{'{-40, 4'h0}, '{-30, 4'h1}, '{-25, 4'h1}, '{-5, 4'h3}, '{5, 4'h4},
                                   '{25, 4'h6}, '{75, 4'hB}, '{80, 4'hC}, '{127, 4'hC}};

  always #5 mclk = ~mclk;

  gauge_status_capacity_regs #(.BLINK_HALF_CYCLES(4), .OVERLOAD_FLAG_HOLD_CYCLES(5)) u_gauge_status_capacity_regs (.*);
  host_bus_model u_host_bus_model (.*);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    u_host_bus_model.rd(a, d);
    compares++;
    if ((d & m) !== (e & m))
    begin
      fails++;
      $display("mismatch reg %h expected %h seen %h", a, e & m, d & m);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #200_000;
    fails++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge mclk) temperature_c <= rows[i].t;
      chk(ADDR_TEMP_GAUGE, 8'hFF, {rows[i].c, 4'h8});
    end
    temperature_c <= 8'sd25;
    // Reset values and unmapped read
    chk(ADDR_STATUS_PRI, 8'h7F, 8'h54);
    chk(ADDR_CAP_HIGH, 8'hFF, 8'h00);
    chk(ADDR_CAP_LOW, 8'hFF, 8'h00);
    chk(ADDR_FULL_REF, 8'hFF, 8'h10);
    chk(ADDR_STATUS_SEC, 8'hFF, 8'h00);
    chk(ADDR_PULLDOWN, 8'hFF, 8'h09);
    chk(7'h30, 8'hFF, 8'h00);
    // Count up to full, saturate, then first discharge from full
    u_host_bus_model.wr(ADDR_CAP_HIGH, 8'h0F);
    u_host_bus_model.wr(ADDR_CAP_LOW, 8'hFF);
    u_host_bus_model.wr(ADDR_TEMP_GAUGE, 8'h00);
    @(posedge mclk) compensated_level <= 8'h20;
    repeat (2)
    begin
      @(posedge mclk) charge_tick <= 1'b1;
      @(posedge mclk) charge_tick <= 1'b0;
      chk(ADDR_CAP_HIGH, 8'hFF, 8'h10);
      chk(ADDR_CAP_LOW, 8'hFF, 8'h00);
    end
    chk(ADDR_TEMP_GAUGE, 8'hFF, 8'h6F);
    @(posedge mclk) discharge_tick <= 1'b1;
    @(posedge mclk) discharge_tick <= 1'b0;
    chk(ADDR_STATUS_PRI, 8'h08, 8'h08);
    chk(ADDR_STATUS_SEC, 8'h04, 8'h00);
    chk(ADDR_CAP_LOW, 8'hFF, 8'hFF);
    // Self-discharge just at and just past the limit
    @(posedge mclk) self_discharge_tick <= 1'b1;
    repeat (245) @(posedge mclk);
    self_discharge_tick <= 1'b0;
    chk(ADDR_STATUS_PRI, 8'h08, 8'h08);
    @(posedge mclk) self_discharge_tick <= 1'b1;
    @(posedge mclk) self_discharge_tick <= 1'b0;
    chk(ADDR_STATUS_PRI, 8'h08, 8'h00);
    // Full again, discharge, then both empty warnings
    u_host_bus_model.wr(ADDR_CAP_HIGH, 8'h10);
    u_host_bus_model.wr(ADDR_CAP_LOW, 8'h00);
    @(posedge mclk) discharge_tick <= 1'b1;
    @(posedge mclk) discharge_tick <= 1'b0;
    cell_voltage <= 8'hA0;
    repeat (3) @(posedge mclk);
    ones = 0;
    repeat (16)
    begin
      @(posedge mclk);
      #1;
      ones += int'(seg_drive[0] === 1'b1);
    end
    compares++;
    if (ones != 8 || seg_drive[4:1] !== 4'hF)
    begin
      fails++;
      $display("mismatch blink expected 8 seen %0d", ones);
    end
    chk(ADDR_STATUS_PRI, 8'h0B, 8'h0A);
    @(posedge mclk) cell_voltage <= 8'h90;
    repeat (3) @(posedge mclk);
    #1;
    compares++;
    if (seg_drive !== 5'h00)
    begin
      fails++;
      $display("mismatch seg_drive expected 00 seen %h", seg_drive);
    end
    chk(ADDR_STATUS_PRI, 8'h0B, 8'h0B);
    // Valid charge learns the reduced reference
    @(posedge mclk) cell_voltage <= 8'hC0;
    @(posedge mclk) valid_charge <= 1'b1;
    chk(ADDR_FULL_REF, 8'hFF, 8'h0F);
    chk(ADDR_STATUS_PRI, 8'h1B, 8'h00);
    chk(ADDR_STATUS_SEC, 8'h04, 8'h04);
    // Discharge from the new full, then sustained charge clears it
    @(posedge mclk) discharge_tick <= 1'b1;
    @(posedge mclk) discharge_tick <= 1'b0;
    chk(ADDR_STATUS_PRI, 8'h08, 8'h08);
    repeat (2)
    begin
      @(posedge mclk) charge_tick <= 1'b1;
      @(posedge mclk) charge_tick <= 1'b0;
    end
    chk(ADDR_STATUS_PRI, 8'h08, 8'h00);
    // Command reset keeps the tag
    @(posedge mclk) valid_charge <= 1'b0;
    u_host_bus_model.wr(ADDR_BATT_TAG, 8'hA5);
    chk(ADDR_BATT_TAG, 8'hFF, 8'hA5);
    @(posedge mclk) soft_reset <= 1'b1;
    @(posedge mclk) soft_reset <= 1'b0;
    chk(ADDR_BATT_TAG, 8'hFF, 8'hA5);
    chk(ADDR_FULL_REF, 8'hFF, 8'h10);
    chk(ADDR_STATUS_PRI, 8'h1B, 8'h10);
    // Rate regimes and overload hold
    @(posedge mclk) rate_half_c <= 1'b1;
    chk(ADDR_STATUS_SEC, 8'h71, 8'h10);
    @(posedge mclk) rate_over_2c <= 1'b1;
    chk(ADDR_STATUS_SEC, 8'h71, 8'h21);
    @(posedge mclk) rate_over_2c <= 1'b0;
    chk(ADDR_STATUS_SEC, 8'h71, 8'h11);
    repeat (8) @(posedge mclk);
    chk(ADDR_STATUS_SEC, 8'h71, 8'h10);
    end_sim();
  end
endmodule // gauge_status_capacity_regs_test
